// File: inc/fmd_pkg.sv
package fmd_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_CTRL2 = 8'h00;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h01;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h02;
  localparam logic [7:0] OFS_STATE = 8'h03;

  // Field layout of clock_gen_control_two
  localparam int LOL_SEL_BIT = 7;
  localparam int MFD_HI = 6;
  localparam int MFD_LO = 4;
  localparam int LOC_SEL_BIT = 3;
  localparam int RFD_HI = 2;
  localparam int RFD_LO = 0;
  localparam int FIELD_W = 3;

  // Event status and mask layout
  localparam int EVT_LOCK_LOSS = 0;
  localparam int EVT_CLOCK_LOSS = 1;
  localparam int EVT_UPDATE_DONE = 2;
  localparam int EVT_W = 3;

  // State register layout
  localparam int ST_MFD_BUSY = 0;
  localparam int ST_RFD_BUSY = 1;
  localparam int ST_RESET_REQ = 2;

  // Reset values
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [2:0] FIELD_RESET = 3'h0;

  // Factor widths
  localparam int MULT_W = 5;
  localparam int DIV_W = 8;
  localparam int REF_W = 12;
  localparam int TARGET_W = REF_W + MULT_W;

  // Code 101 values
  localparam logic [4:0] MULT_CODE5 = 5'h0c;
  localparam logic [7:0] DIV_CODE5 = 8'h20;

  // Time for a field write to settle into the loop
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 4;

  // Update sequencer states
  typedef enum logic [1:0] {
    FMD_UPD_IDLE = 2'b01,
    FMD_UPD_WAIT = 2'b10
  } fmd_upd_state_t;

  // Multiplication factor for each code
  function automatic logic [4:0] mult_of(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h04;
    case (code)
      3'h0: n = 5'h04;
      3'h1: n = 5'h06;
      3'h2: n = 5'h08;
      3'h3: n = 5'h0a;
      3'h4: n = 5'h0e;
      3'h5: n = MULT_CODE5;
      3'h6: n = 5'h10;
      default: n = 5'h12;
    endcase
    return n;
  endfunction

  // Division factor for each code
  function automatic logic [7:0] div_of(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h01;
    case (code)
      3'h0: r = 8'h01;
      3'h1: r = 8'h02;
      3'h2: r = 8'h04;
      3'h3: r = 8'h08;
      3'h4: r = 8'h10;
      3'h5: r = DIV_CODE5;
      3'h6: r = 8'h40;
      default: r = 8'h80;
    endcase
    return r;
  endfunction

endpackage

// File: rtl/fmd_field_update.sv
`timescale 1ns/1ns
`default_nettype none

// Takes a new field value, holds it pending while the loop settles, then
// makes it effective; writes arriving while pending are dropped.
module fmd_field_update (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wr,
  input wire logic [2:0] wdata,
  output logic busy,
  output logic [2:0] pend,
  output logic [2:0] field,
  output logic done
);

  fmd_pkg::fmd_upd_state_t state;
  logic [3:0] cnt;
  wire logic accept;
  wire logic expire;

  // Only an idle sequencer takes a write
  assign accept = wr && (state == fmd_pkg::FMD_UPD_IDLE);
  assign expire = (state == fmd_pkg::FMD_UPD_WAIT) && (cnt == 4'h1);
  assign busy = (state == fmd_pkg::FMD_UPD_WAIT);

  // Sequencer, pending value and settle counter
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= fmd_pkg::FMD_UPD_IDLE;
      cnt <= 4'h0;
      pend <= fmd_pkg::FIELD_RESET;
      field <= fmd_pkg::FIELD_RESET;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= expire;
      case (state)
        fmd_pkg::FMD_UPD_IDLE:
        begin
          if (accept)
          begin
            pend <= wdata;
            cnt <= fmd_pkg::SETTLE_CNT_W'(fmd_pkg::SETTLE_CYC);
            state <= fmd_pkg::FMD_UPD_WAIT;
          end
        end
        fmd_pkg::FMD_UPD_WAIT:
        begin
          cnt <= cnt - 4'h1;
          if (expire)
          begin
            field <= pend;
            state <= fmd_pkg::FMD_UPD_IDLE;
          end
        end
        default: state <= fmd_pkg::FMD_UPD_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: rtl/fmd_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// [R01] Lock-loss select: clear interrupt, set reset
// [R02] Lock-loss select matters only with flag set
// [R03] Multiply field codes map to factor N
// [R04] Multiply write ignored while earlier one pending
// [R05] Factor N scales reference into DCO target
// [R06] Software keeps N within DCO maximum
// [R07] Clock-loss select: clear interrupt, set reset
// [R08] Divide field codes map to factor R
// [R09] R divides the selected source clock
// [R10] Divide write ignored while earlier one pending
// [R11] Multiply code 101 gives twelve
// [R12] Divide code 101 gives thirty-two
module fmd_ctrl (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic LOCK_LOSS,
  input wire logic CLOCK_LOSS,
  input wire logic [11:0] REF_COUNT,
  input wire logic SRC_TICK,
  output logic [4:0] FLL_FACTOR,
  output logic [7:0] DIV_FACTOR,
  output logic [16:0] DCO_TARGET,
  output logic OUT_TICK,
  output logic IRQ,
  output logic RESET_REQ
);

  // Software-visible state and the divider counter
  logic lock_loss_reset_select;
  logic clock_loss_reset_select;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic [7:0] div_cnt;

  // Field sequencer outputs
  wire logic [2:0] fll_multiply_field;
  wire logic [2:0] output_divide_field;
  wire logic [2:0] mfd_pend;
  wire logic [2:0] rfd_pend;
  wire logic mfd_busy;
  wire logic rfd_busy;
  wire logic mfd_done;
  wire logic rfd_done;

  // Address decode
  wire logic sel_ctrl = (ADDR == fmd_pkg::OFS_CTRL2);
  wire logic sel_stat = (ADDR == fmd_pkg::OFS_EVENT_STATUS);
  wire logic sel_mask = (ADDR == fmd_pkg::OFS_EVENT_MASK);
  wire logic sel_state = (ADDR == fmd_pkg::OFS_STATE);
  wire logic wr_ctrl = WR && sel_ctrl;
  wire logic wr_stat = WR && sel_stat;
  wire logic wr_mask = WR && sel_mask;

  // Flags and requests
  wire logic lock_loss_status_flag = evt_status[fmd_pkg::EVT_LOCK_LOSS];
  wire logic clock_loss_flag = evt_status[fmd_pkg::EVT_CLOCK_LOSS];
  wire logic [2:0] evt_set;
  wire logic [2:0] evt_clr;
  wire logic [2:0] next_evt_status;
  wire logic [2:0] irq_route;
  wire logic next_irq;
  wire logic next_reset_req;

  // Register views
  wire logic [7:0] ctrl_view;
  wire logic [7:0] state_view;
  wire logic [7:0] next_rdata;

  // Divider terms
  wire logic [7:0] div_last;
  wire logic div_wrap;

  // Hardware sets win over a same-cycle write-one clear
  assign evt_set = {mfd_done | rfd_done, CLOCK_LOSS, LOCK_LOSS};
  assign evt_clr = wr_stat ? WDATA[fmd_pkg::EVT_W-1:0] : 3'h0;
  assign next_evt_status = (evt_status & ~evt_clr) | evt_set;

  // A loss event goes to reset when its select is set, otherwise to the interrupt
  assign irq_route = {1'b1, ~clock_loss_reset_select, ~lock_loss_reset_select}; // R01 R07
  assign next_irq = |(evt_status & evt_mask & irq_route);
  // Lock-loss select only acts through the set flag
  assign next_reset_req = (lock_loss_status_flag && lock_loss_reset_select) // R02
    || (clock_loss_flag && clock_loss_reset_select); // R07

  // Read views
  assign ctrl_view = {lock_loss_reset_select, fll_multiply_field, clock_loss_reset_select, output_divide_field};
  assign state_view = {5'h00, RESET_REQ, rfd_busy, mfd_busy};
  assign next_rdata = !RD ? 8'h00 :
    sel_ctrl ? ctrl_view :
    sel_stat ? {5'h00, evt_status} :
    sel_mask ? {5'h00, evt_mask} :
    sel_state ? state_view : 8'h00;

  // Output divider runs on source ticks; R of one passes every tick
  assign div_last = DIV_FACTOR - 8'h01;
  assign div_wrap = (div_cnt >= div_last); // R09

  // Multiply field update; a write while pending is dropped inside
  fmd_field_update u_mfd ( // R04
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .ce(CE),
    .wr(wr_ctrl),
    .wdata(WDATA[fmd_pkg::MFD_HI:fmd_pkg::MFD_LO]),
    .busy(mfd_busy),
    .pend(mfd_pend),
    .field(fll_multiply_field),
    .done(mfd_done)
  );

  // Divide field update, same sequencing
  fmd_field_update u_rfd ( // R10
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .ce(CE),
    .wr(wr_ctrl),
    .wdata(WDATA[fmd_pkg::RFD_HI:fmd_pkg::RFD_LO]),
    .busy(rfd_busy),
    .pend(rfd_pend),
    .field(output_divide_field),
    .done(rfd_done)
  );

  // Select bits take effect at once; they have no loop to settle
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      lock_loss_reset_select <= fmd_pkg::CTRL2_RESET[fmd_pkg::LOL_SEL_BIT];
      clock_loss_reset_select <= fmd_pkg::CTRL2_RESET[fmd_pkg::LOC_SEL_BIT];
    end
    else if (CE && wr_ctrl)
    begin
      lock_loss_reset_select <= WDATA[fmd_pkg::LOL_SEL_BIT]; // R01
      clock_loss_reset_select <= WDATA[fmd_pkg::LOC_SEL_BIT]; // R07
    end
  end

  // Event status, mask and the two request outputs
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      evt_status <= fmd_pkg::EVT_RESET;
      evt_mask <= fmd_pkg::EVT_RESET;
      IRQ <= 1'b0;
      RESET_REQ <= 1'b0;
    end
    else if (CE)
    begin
      evt_status <= next_evt_status;
      if (wr_mask)
        evt_mask <= WDATA[fmd_pkg::EVT_W-1:0];
      IRQ <= next_irq;
      RESET_REQ <= next_reset_req;
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= 8'h00;
    else if (CE)
      RDATA <= next_rdata;
  end

  // Factors follow the effective fields; target is registered to keep the product off the output path
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FLL_FACTOR <= fmd_pkg::mult_of(fmd_pkg::FIELD_RESET);
      DIV_FACTOR <= fmd_pkg::div_of(fmd_pkg::FIELD_RESET);
      DCO_TARGET <= 17'h00000;
    end
    else if (CE)
    begin
      FLL_FACTOR <= fmd_pkg::mult_of(fll_multiply_field); // R03 R11
      DIV_FACTOR <= fmd_pkg::div_of(output_divide_field); // R08 R12
      DCO_TARGET <= {5'h00, REF_COUNT} * {12'h000, FLL_FACTOR}; // R05
    end
  end

  // Divider counter; a factor change restarts nothing, the compare just moves
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      div_cnt <= 8'h00;
      OUT_TICK <= 1'b0;
    end
    else if (CE)
    begin
      OUT_TICK <= SRC_TICK && div_wrap; // R09
      if (SRC_TICK)
        div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // Checks

  sequence mfd_accept_s;
    CE && wr_ctrl && !mfd_busy;
  endsequence

  sequence rfd_accept_s;
    CE && wr_ctrl && !rfd_busy;
  endsequence

  // Ten enabled cycles, split in two because long repetitions unroll badly
  sequence settle_s;
    CE [*8] ##1 CE [*2];
  endsequence

  sequence rfd_reject_s;
    CE && wr_ctrl && rfd_busy;
  endsequence

  lol_reset_route_a: assert property ( // R01
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && lock_loss_status_flag && lock_loss_reset_select |=> RESET_REQ)
    else $error("lock loss with reset select gave no reset request");

  lol_irq_route_a: assert property ( // R01
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && lock_loss_status_flag && !lock_loss_reset_select && evt_mask[fmd_pkg::EVT_LOCK_LOSS] |=> IRQ)
    else $error("lock loss with interrupt select gave no interrupt");

  lol_no_effect_a: assert property ( // R02
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && !lock_loss_status_flag && !clock_loss_flag |=> !RESET_REQ)
    else $error("reset request without a loss flag");

  mult_map_a: assert property ( // R03
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE |=> FLL_FACTOR == fmd_pkg::mult_of($past(fll_multiply_field)))
    else $error("multiply factor does not match field");

  mfd_settle_a: assert property ( // R04
    @(posedge CLK_SYS) disable iff (!RST_B)
    mfd_accept_s ##1 settle_s |=> !mfd_busy && fll_multiply_field == $past(mfd_pend))
    else $error("multiply write did not take effect after settling");

  mfd_ignore_a: assert property ( // R04
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && wr_ctrl && mfd_busy |=> mfd_pend == $past(mfd_pend))
    else $error("multiply write taken while pending");

  dco_target_a: assert property ( // R05
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE |=> DCO_TARGET == {5'h00, $past(REF_COUNT)} * {12'h000, $past(FLL_FACTOR)})
    else $error("DCO target is not reference times factor");

  loc_route_a: assert property ( // R07
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && clock_loss_flag && clock_loss_reset_select |=> RESET_REQ)
    else $error("clock loss with reset select gave no reset request");

  div_map_a: assert property ( // R08
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE |=> DIV_FACTOR == fmd_pkg::div_of($past(output_divide_field)))
    else $error("divide factor does not match field");

  div_tick_a: assert property ( // R09
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && !SRC_TICK |=> !OUT_TICK)
    else $error("output tick without a source tick");

  div_pass_a: assert property ( // R09
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && SRC_TICK && DIV_FACTOR == 8'h01 |=> OUT_TICK)
    else $error("divide by one dropped a tick");

  rfd_ignore_a: assert property ( // R10
    @(posedge CLK_SYS) disable iff (!RST_B)
    rfd_reject_s |=> rfd_pend == $past(rfd_pend))
    else $error("divide write taken while pending");

  mult_code5_a: assert property ( // R11
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && fll_multiply_field == 3'h5 |=> FLL_FACTOR == fmd_pkg::MULT_CODE5)
    else $error("multiply code 101 is not twelve");

  div_code5_a: assert property ( // R12
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && output_divide_field == 3'h5 |=> DIV_FACTOR == fmd_pkg::DIV_CODE5)
    else $error("divide code 101 is not thirty-two");

  rfd_settle_a: assert property ( // R10
    @(posedge CLK_SYS) disable iff (!RST_B)
    rfd_accept_s ##1 settle_s |=> !rfd_busy && output_divide_field == $past(rfd_pend))
    else $error("divide write did not take effect after settling");

  mfd_pend_take_a: assert property ( // R04
    @(posedge CLK_SYS) disable iff (!RST_B)
    mfd_accept_s |=> mfd_busy && mfd_pend == $past(WDATA[fmd_pkg::MFD_HI:fmd_pkg::MFD_LO]))
    else $error("idle multiply sequencer did not take the write");

  rfd_pend_take_a: assert property ( // R10
    @(posedge CLK_SYS) disable iff (!RST_B)
    rfd_accept_s |=> rfd_busy && rfd_pend == $past(WDATA[fmd_pkg::RFD_HI:fmd_pkg::RFD_LO]))
    else $error("idle divide sequencer did not take the write");

  loc_irq_route_a: assert property ( // R07
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && clock_loss_flag && !clock_loss_reset_select && evt_mask[fmd_pkg::EVT_CLOCK_LOSS] |=> IRQ)
    else $error("clock loss with interrupt select gave no interrupt");

  loc_no_reset_a: assert property ( // R07
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && !clock_loss_reset_select && !(lock_loss_status_flag && lock_loss_reset_select) |=> !RESET_REQ)
    else $error("reset request with both routes set to interrupt");

  lol_sel_write_a: assert property ( // R01
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && wr_ctrl |=> lock_loss_reset_select == $past(WDATA[fmd_pkg::LOL_SEL_BIT]))
    else $error("lock loss select not written");

  loc_sel_write_a: assert property ( // R07
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && wr_ctrl |=> clock_loss_reset_select == $past(WDATA[fmd_pkg::LOC_SEL_BIT]))
    else $error("clock loss select not written");

  mfd_done_flag_a: assert property ( // R04
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && mfd_done |=> evt_status[fmd_pkg::EVT_UPDATE_DONE])
    else $error("multiply update end did not set the done flag");

  rfd_done_flag_a: assert property ( // R10
    @(posedge CLK_SYS) disable iff (!RST_B)
    CE && rfd_done |=> evt_status[fmd_pkg::EVT_UPDATE_DONE])
    else $error("divide update end did not set the done flag");

endmodule

`default_nettype wire

// File: testbench/fll_multiply_divide_control_bench.sv
`timescale 1ns/1ns
`default_nettype none

module fll_multiply_divide_control_bench;
  logic clk_sys;
  logic rst_b;
  logic ce;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic lock_loss;
  logic clock_loss;
  logic [11:0] ref_count;
  logic src_tick;
  logic [4:0] fll_factor;
  logic [7:0] div_factor;
  logic [16:0] dco_target;
  logic out_tick;
  logic irq;
  logic reset_req;
  int err_count;
  int total_checks;
  logic [4:0] mult_tab [8];
  logic [7:0] div_tab [8];

  fmd_ctrl fmd_ctrl_inst (
    .CLK_SYS(clk_sys),
    .RST_B(rst_b),
    .CE(ce),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .RDATA(rdata),
    .LOCK_LOSS(lock_loss),
    .CLOCK_LOSS(clock_loss),
    .REF_COUNT(ref_count),
    .SRC_TICK(src_tick),
    .FLL_FACTOR(fll_factor),
    .DIV_FACTOR(div_factor),
    .DCO_TARGET(dco_target),
    .OUT_TICK(out_tick),
    .IRQ(irq),
    .RESET_REQ(reset_req)
  );

  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Compare and count; an unknown never matches
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict; also reached from the watchdog
  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Ticks every cycle, so the gap between divided ticks equals R
  task automatic div_gap(input logic [7:0] r);
    int k;
    int n;
    k = 0;
    n = 0;
    @(posedge clk_sys);
    src_tick <= 1'b1;
    @(posedge clk_sys);
    #1;
    while (out_tick !== 1'b1 && k < 600)
    begin
      @(posedge clk_sys);
      #1 k++;
    end
    do
    begin
      @(posedge clk_sys);
      #1 n++;
    end while (out_tick !== 1'b1 && n < 300);
    @(posedge clk_sys);
    src_tick <= 1'b0;
    chk(17'(n), {9'h0, r});
  endtask

  // Reset values and an unmapped place
  task automatic t_reset;
    logic [7:0] v;
    chk({12'h0, fll_factor}, 17'h4);
    chk({9'h0, div_factor}, 17'h1);
    chk({15'h0, irq, reset_req}, 17'h0);
    rd_reg(fmd_pkg::OFS_CTRL2, v);
    chk({9'h0, v}, 17'h0);
    wr_reg(8'h10, 8'hff);
    rd_reg(8'h10, v);
    chk({9'h0, v}, 17'h0);
    rd_reg(fmd_pkg::OFS_EVENT_MASK, v);
    chk({9'h0, v}, 17'h0);
  endtask

  // Every multiply and divide code, readback and factors
  task automatic t_codes;
    logic [7:0] v;
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      wr_reg(fmd_pkg::OFS_CTRL2, {1'b0, c, 1'b0, c});
      repeat (14) @(posedge clk_sys);
      #1;
      chk({12'h0, fll_factor}, {12'h0, mult_tab[i]});
      chk(dco_target, {5'h0, ref_count} * {12'h0, mult_tab[i]});
      chk({9'h0, div_factor}, {9'h0, div_tab[i]});
      rd_reg(fmd_pkg::OFS_CTRL2, v);
      chk({9'h0, v}, {9'h0, 1'b0, c, 1'b0, c});
      div_gap(div_tab[i]);
    end
  endtask

  // Second write while pending: fields dropped, selects taken
  task automatic t_busy;
    logic [7:0] v;
    wr_reg(fmd_pkg::OFS_EVENT_STATUS, 8'h07);
    wr_reg(fmd_pkg::OFS_CTRL2, 8'h55);
    rd_reg(fmd_pkg::OFS_STATE, v);
    chk({9'h0, v}, 17'h3);
    wr_reg(fmd_pkg::OFS_CTRL2, 8'hff);
    repeat (14) @(posedge clk_sys);
    #1;
    chk({12'h0, fll_factor}, 17'hc);
    chk({9'h0, div_factor}, 17'h20);
    chk({16'h0, reset_req}, 17'h0);
    rd_reg(fmd_pkg::OFS_EVENT_STATUS, v);
    chk({9'h0, v}, 17'h4);
    rd_reg(fmd_pkg::OFS_CTRL2, v);
    chk({9'h0, v}, 17'hdd);
  endtask

  // Enable low: a register write and a loss event must both be ignored
  task automatic t_hold;
    logic [7:0] v;
    @(posedge clk_sys);
    ce <= 1'b0;
    lock_loss <= 1'b1;
    wr_reg(fmd_pkg::OFS_CTRL2, 8'h07);
    @(posedge clk_sys);
    ce <= 1'b1;
    lock_loss <= 1'b0;
    repeat (14) @(posedge clk_sys);
    #1;
    chk({9'h0, div_factor}, 17'h20);
    chk({16'h0, reset_req}, 17'h0);
    rd_reg(fmd_pkg::OFS_CTRL2, v);
    chk({9'h0, v}, 17'hdd);
  endtask

  // Event routing: b 0 lock loss, 1 clock loss
  task automatic t_event(input int b, input logic sel, input logic [7:0] m);
    logic [7:0] v;
    logic [7:0] bit_b;
    bit_b = 8'h1 << b;
    wr_reg(fmd_pkg::OFS_CTRL2, sel ? (b == 0 ? 8'h80 : 8'h08) : 8'h00);
    wr_reg(fmd_pkg::OFS_EVENT_MASK, m);
    #1;
    chk({15'h0, irq, reset_req}, 17'h0);
    @(posedge clk_sys);
    lock_loss <= (b == 0);
    clock_loss <= (b == 1);
    @(posedge clk_sys);
    lock_loss <= 1'b0;
    clock_loss <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({16'h0, irq}, {16'h0, ~sel & |(m & bit_b)});
    chk({16'h0, reset_req}, {16'h0, sel});
    rd_reg(fmd_pkg::OFS_EVENT_STATUS, v);
    chk({9'h0, v & 8'h03}, {9'h0, bit_b});
    rd_reg(fmd_pkg::OFS_STATE, v);
    chk({16'h0, v[2]}, {16'h0, sel});
    wr_reg(fmd_pkg::OFS_EVENT_STATUS, 8'h07);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({15'h0, irq, reset_req}, 17'h0);
  endtask

  // Watchdog well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    mult_tab = '{5'h04, 5'h06, 5'h08, 5'h0a, 5'h0e, 5'h0c, 5'h10, 5'h12};
    div_tab = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    err_count = 0;
    total_checks = 0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    lock_loss = 1'b0;
    clock_loss = 1'b0;
    ref_count = 12'h123;
    src_tick = 1'b0;
    ce = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_codes();
    t_busy();
    t_hold();
    t_event(0, 1'b0, 8'h03);
    t_event(0, 1'b0, 8'h00);
    t_event(0, 1'b1, 8'h03);
    t_event(1, 1'b0, 8'h03);
    t_event(1, 1'b0, 8'h00);
    t_event(1, 1'b1, 8'h03);
    finish_test();
  end
endmodule

`default_nettype wire
